// ==== spep_map.vh ====
/*
 Constants for the serial EEPROM pin and write-protect logic.
 Assumes inclusion by bare name from the design files in this folder.
*/
// Function
// - After power-up sit in standby, treating chip select as high, until selected.
// - Power-up clears the write enable latch.
// - Power-up leaves the serial data output undriven.
// - No command accepted until chip select has fallen after power-up.
// - Latch clear rejects all writes; protected blocks never writable.
// - Protect enable set and write-protect pin low refuses status writes.
// - Write-protect pin high allows all writes outside protected blocks when latch is set.
// - Protect enable clear makes the write-protect pin ignored.
// - A started internal write completes despite write-protect pin falling.
// - Chip select low selects; high deselects into standby.
// - Started programming cycle completes; standby follows its end.
// - Deselected device releases its serial data output.
// - Internal write starts on chip select rise after a complete write sequence.
// - Input bits are captured on serial clock rising edges.
// - Read data changes after serial clock falling edges.
// - Pause low suspends transfer and keeps sequence state.
// - Pause lowered with clock high takes effect at next clock fall.
// - While paused, clock and data input transitions are ignored.
// - Resume only when pause rises while the clock is low; code resumes at the first clock low after pause rises.
// - Pause low immediately tri-states the serial data output.
// - Opcodes: read 03h, write 02h, set latch 06h.
// - Opcodes: clear latch 04h, read status 05h, write status 01h.
// - Block protect 00 none, 01 0600h-07FFh, 10 0400h-07FFh, 11 all.
// - Latch cleared at power-up and after clear-latch, status write, array write.
`ifndef SPEP_MAP_VH
`define SPEP_MAP_VH
`define SPEP_OP_READ 8'h03
`define SPEP_OP_WRITE 8'h02
`define SPEP_OP_SETWL 8'h06
`define SPEP_OP_CLRWL 8'h04
`define SPEP_OP_STATUS_READ_CMD 8'h05
`define SPEP_OP_STATUS_WRITE_CMD 8'h01
`define SPEP_SR_WIP 0
`define SPEP_SR_WEL 1
`define SPEP_SR_BPL 2
`define SPEP_SR_BPH 3
`define SPEP_SR_SPE 7
`define SPEP_QUARTER_BASE 11'h600
`define SPEP_HALF_BASE 11'h400
`define SPEP_ADDR_W 11
`define SPEP_PAGE_W 5
`define SPEP_STATUS_RESET 4'h0
`define SPEP_WRITE_CYCLES 20'h186a0
`endif

// ==== spep_sync.v ====
/*
 Two-flop synchroniser with edge flags taken after the second flop.
 Assumes the input is asynchronous to sys_clk_in; init_in is the idle level of the pin.
*/
`timescale 1ns/1ps
module spep_sync (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   input wire init_in,
   // Asynchronous level
   input wire async_in,
   // Synchronised level and edges
   output wire level_out,
   output wire rise_out,
   output wire fall_out
);
   reg meta_q;
   reg sync_q;
   reg prev_q;
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         meta_q <= init_in;
         sync_q <= init_in;
         prev_q <= init_in;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level_out = sync_q;
   assign rise_out = sync_q & ~prev_q;
   assign fall_out = ~sync_q & prev_q;
endmodule

// ==== spep_timer.v ====
/*
 Self-timed programming cycle counter.
 Assumes start_in is a one-cycle pulse; a start while busy is ignored.
*/
`timescale 1ns/1ps
`include "spep_map.vh"
module spep_timer #(
   parameter [19:0] CYCLES = `SPEP_WRITE_CYCLES
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Control
   input wire start_in,
   output wire busy_out,
   output wire done_out
);
   reg [19:0] cnt_q;
   always @(posedge sys_clk_in) begin
      if (!rstn_in)
         cnt_q <= 20'h00000;
      else if (start_in && cnt_q == 20'h00000)
         cnt_q <= CYCLES;
      else if (cnt_q != 20'h00000)
         cnt_q <= cnt_q - 20'h00001;
   end
   assign busy_out = (cnt_q != 20'h00000);
   assign done_out = (cnt_q == 20'h00001);
endmodule

// ==== spep_core.v ====
/*
 Serial EEPROM slave pin logic: selection, sampling, pause, status register,
 write-protect decision and self-timed cycle start. The array itself is outside:
 array writes leave through arr_wr_* strobes, reads come back on arr_rd_data_in.
 Assumes all pins are asynchronous to sys_clk_in, which runs well above the
 serial clock.
*/
`timescale 1ns/1ps
`include "spep_map.vh"
module spep_core #(
   parameter [19:0] WRITE_CYCLES = `SPEP_WRITE_CYCLES
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Serial pins
   input wire cs_n_in,
   input wire sck_in,
   input wire si_in,
   input wire hold_n_in,
   input wire wp_n_in,
   output reg so_out,
   output reg so_oe_out,
   // Array port
   output reg [`SPEP_ADDR_W-1:0] arr_addr_out,
   output reg [7:0] arr_wr_data_out,
   output reg arr_wr_out,
   output reg arr_commit_out,
   input wire [7:0] arr_rd_data_in,
   // Status
   output wire [7:0] status_out,
   output wire busy_out,
   output wire standby_out
);
   localparam ST_OP = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_WDATA = 3'd2;
   localparam ST_RDATA = 3'd3;
   localparam ST_SRDATA = 3'd4;
   localparam ST_WSR = 3'd5;
   localparam ST_IGNORE = 3'd6;

   wire cs_n;
   wire cs_rise;
   wire cs_fall;
   wire sck;
   wire sck_rise;
   wire sck_fall;
   wire si;
   wire hold_n;
   wire wp_n;
   wire busy;
   wire done;
   reg start_q;

   spep_sync u_cs (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .init_in(1'b1),
      .async_in(cs_n_in), .level_out(cs_n), .rise_out(cs_rise), .fall_out(cs_fall));
   spep_sync u_sck (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .init_in(1'b1),
      .async_in(sck_in), .level_out(sck), .rise_out(sck_rise), .fall_out(sck_fall));
   spep_sync u_si (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .init_in(1'b1),
      .async_in(si_in), .level_out(si), .rise_out(), .fall_out());
   spep_sync u_hold (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .init_in(1'b1),
      .async_in(hold_n_in), .level_out(hold_n), .rise_out(), .fall_out());
   spep_sync u_wp (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .init_in(1'b1),
      .async_in(wp_n_in), .level_out(wp_n), .rise_out(), .fall_out());
   spep_timer #(.CYCLES(WRITE_CYCLES)) u_timer (.sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in), .start_in(start_q), .busy_out(busy), .done_out(done));

   reg armed_q;
   reg [1:0] settle_q;
   reg active_q;
   reg paused_q;
   reg [2:0] state_q;
   reg [4:0] bit_q;
   reg [7:0] shift_q;
   reg [15:0] addr_q;
   reg [7:0] out_q;
   reg wel_q;
   reg spe_q;
   reg [1:0] bp_q;
   reg [1:0] bp_new_q;
   reg spe_new_q;
   reg byte_done_q;
   reg rd_load_q;
   reg seq_arr_q;
   reg any_data_q;
   reg blocked_q;
   reg pend_wsr_q;
   reg standby_q;

   wire selected = active_q & ~cs_n;
   // Clock rising edges are ignored while paused
   wire shift_in = selected & ~paused_q & sck_rise;
   wire shift_out = selected & ~paused_q & sck_fall;
   wire [7:0] byte_in = {shift_q[6:0], si};
   wire [7:0] status = {spe_q, 3'b000, bp_q, wel_q, busy};

   // Block protection of an address
   function prot;
      input [1:0] bp;
      input [`SPEP_ADDR_W-1:0] a;
      begin
         case (bp)
            2'b00: prot = 1'b0;
            2'b01: prot = (a >= `SPEP_QUARTER_BASE);
            2'b10: prot = (a >= `SPEP_HALF_BASE);
            default: prot = 1'b1;
         endcase
      end
   endfunction

   wire [`SPEP_ADDR_W-1:0] cur_addr = addr_q[`SPEP_ADDR_W-1:0];
   wire hw_protect = spe_q & ~wp_n;

   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         armed_q <= 1'b0;
         settle_q <= 2'b00;
         active_q <= 1'b0;
         paused_q <= 1'b0;
         state_q <= ST_OP;
         bit_q <= 5'd0;
         shift_q <= 8'h00;
         addr_q <= 16'h0000;
         out_q <= 8'h00;
         wel_q <= 1'b0;
         spe_q <= 1'b0;
         bp_q <= 2'b00;
         bp_new_q <= 2'b00;
         spe_new_q <= 1'b0;
         byte_done_q <= 1'b0;
         rd_load_q <= 1'b0;
         seq_arr_q <= 1'b0;
         any_data_q <= 1'b0;
         blocked_q <= 1'b0;
         pend_wsr_q <= 1'b0;
         start_q <= 1'b0;
         standby_q <= 1'b1;
         arr_addr_out <= {`SPEP_ADDR_W{1'b0}};
         arr_wr_data_out <= 8'h00;
         arr_wr_out <= 1'b0;
         arr_commit_out <= 1'b0;
      end else begin
         start_q <= 1'b0;
         arr_wr_out <= 1'b0;
         arr_commit_out <= 1'b0;
         rd_load_q <= 1'b0;
         // Array data is taken one cycle after the address has moved
         if (rd_load_q)
            out_q <= arr_rd_data_in;
         // Arm on a high level seen once the synchronisers hold real pin values
         if (settle_q != 2'b11)
            settle_q <= settle_q + 2'b01;
         else if (cs_n)
            armed_q <= 1'b1;
         if (cs_fall && armed_q) begin
            active_q <= 1'b1;
            standby_q <= 1'b0;
         end
         // Pause entry waits for the clock to be low; exit needs the clock low too
         if (!selected)
            paused_q <= 1'b0;
         else if (!paused_q && !hold_n && !sck)
            paused_q <= 1'b1;
         else if (paused_q && hold_n && !sck)
            paused_q <= 1'b0;
         if (cs_rise) begin
            active_q <= 1'b0;
            state_q <= ST_OP;
            bit_q <= 5'd0;
            paused_q <= 1'b0;
            // Only a write ending exactly on a byte boundary commits
            if (state_q == ST_WDATA && bit_q == 5'd0 && any_data_q && !busy
               && !blocked_q) begin
               start_q <= 1'b1;
               arr_commit_out <= 1'b1;
               wel_q <= 1'b0;
            end
            if (state_q == ST_WSR && byte_done_q && !busy && wel_q && !hw_protect) begin
               start_q <= 1'b1;
               pend_wsr_q <= 1'b1;
               wel_q <= 1'b0;
            end
            if (state_q == ST_IGNORE && byte_done_q && !busy) begin
               if (shift_q == `SPEP_OP_SETWL)
                  wel_q <= 1'b1;
               else if (shift_q == `SPEP_OP_CLRWL)
                  wel_q <= 1'b0;
            end
         end else if (shift_in) begin
            shift_q <= byte_in;
            byte_done_q <= 1'b0;
            bit_q <= (bit_q == 5'd7 && state_q != ST_ADDR) ? 5'd0 : bit_q + 5'd1;
            case (state_q)
               ST_OP: begin
                  if (bit_q == 5'd7) begin
                     byte_done_q <= 1'b1;
                     any_data_q <= 1'b0;
                     blocked_q <= ~wel_q;
                     case (byte_in)
                        `SPEP_OP_READ, `SPEP_OP_WRITE: begin
                           state_q <= ST_ADDR;
                           seq_arr_q <= (byte_in == `SPEP_OP_WRITE);
                        end
                        `SPEP_OP_STATUS_READ_CMD: begin
                           state_q <= ST_SRDATA;
                           out_q <= status;
                        end
                        `SPEP_OP_STATUS_WRITE_CMD: state_q <= ST_WSR;
                        default: state_q <= ST_IGNORE;
                     endcase
                  end
               end
               ST_ADDR: begin
                  addr_q <= {addr_q[14:0], si};
                  if (bit_q == 5'd15) begin
                     bit_q <= 5'd0;
                     if (seq_arr_q) begin
                        state_q <= ST_WDATA;
                     end else begin
                        state_q <= ST_RDATA;
                        rd_load_q <= 1'b1;
                        addr_q <= {addr_q[14:0], si} + 16'h0001;
                     end
                  end
                  arr_addr_out <= {addr_q[9:0], si};
               end
               ST_WDATA: begin
                  if (bit_q == 5'd7) begin
                     any_data_q <= 1'b1;
                     arr_addr_out <= cur_addr;
                     arr_wr_data_out <= byte_in;
                     // Reject the whole sequence if any byte targets a protected block
                     if (prot(bp_q, cur_addr) || busy)
                        blocked_q <= 1'b1;
                     else
                        arr_wr_out <= 1'b1;
                     addr_q[`SPEP_PAGE_W-1:0] <= addr_q[`SPEP_PAGE_W-1:0] + 1'b1;
                  end
               end
               ST_RDATA: begin
                  if (bit_q == 5'd7) begin
                     rd_load_q <= 1'b1;
                     arr_addr_out <= cur_addr;
                     addr_q <= addr_q + 16'h0001;
                  end
               end
               ST_SRDATA: begin
                  if (bit_q == 5'd7)
                     out_q <= status;
               end
               ST_WSR: begin
                  if (bit_q == 5'd7) begin
                     byte_done_q <= 1'b1;
                     bp_new_q <= {byte_in[`SPEP_SR_BPH], byte_in[`SPEP_SR_BPL]};
                     spe_new_q <= byte_in[`SPEP_SR_SPE];
                  end
               end
               default: begin
               end
            endcase
         end
         // Status bits settle when the timed cycle ends, whatever the pins do
         if (done) begin
            if (pend_wsr_q) begin
               bp_q <= bp_new_q;
               spe_q <= spe_new_q;
            end
            pend_wsr_q <= 1'b0;
         end
         // A cycle just started is not yet busy but must still hold off standby
         if (!active_q && !busy && !start_q && !cs_fall)
            standby_q <= 1'b1;
      end
   end

   // Output bit advances after each falling clock edge
   reg [2:0] obit_q;
   reg drive_q;
   wire rd_state = (state_q == ST_RDATA) || (state_q == ST_SRDATA);
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         so_out <= 1'b0;
         so_oe_out <= 1'b0;
         obit_q <= 3'd0;
         drive_q <= 1'b0;
      end else begin
         if (!selected || cs_rise) begin
            so_oe_out <= 1'b0;
            obit_q <= 3'd0;
            drive_q <= 1'b0;
         end else begin
            if (shift_out && rd_state) begin
               drive_q <= 1'b1;
               so_out <= out_q[3'd7 - obit_q];
               obit_q <= obit_q + 3'd1;
            end
            // Pause floats the output at once; the bit in flight is kept for the resume
            so_oe_out <= (drive_q | (shift_out & rd_state)) & hold_n & ~paused_q;
         end
      end
   end

   assign status_out = status;
   assign busy_out = busy;
   assign standby_out = standby_q;
endmodule

// ==== spep_core_properties.sv ====
/* Checker on the pins of spep_core.
   Assumes a bind to spep_core run with a short write time. */
`timescale 1ns/1ps
module spep_chk #(
   parameter [19:0] WRITE_CYCLES = 20'd20
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Serial pins
   input wire cs_n_in,
   input wire sck_in,
   input wire hold_n_in,
   input wire so_out,
   input wire so_oe_out,
   // Status
   input wire arr_commit_out,
   input wire [7:0] status_out,
   input wire busy_out,
   input wire standby_out
);
   localparam int BLO = WRITE_CYCLES - 3;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   reset_state_a: assert property (disable iff (1'b0)
      !rstn_in |=> !so_oe_out && standby_out && !busy_out && status_out == 8'h00)
      else $error("power-on state wrong");
   desel_hiz_a: assert property (cs_n_in [*4] |-> !so_oe_out)
      else $error("output driven while deselected");
   hold_hiz_a: assert property (!hold_n_in [*4] |-> !so_oe_out)
      else $error("output driven while paused");
   standby_a: assert property ((cs_n_in && !busy_out) [*8] |-> standby_out)
      else $error("no standby while deselected");
   busy_stby_a: assert property (busy_out |-> !standby_out)
      else $error("standby during write cycle");
   commit_wel_a: assert property (arr_commit_out |-> $past(status_out[1]))
      else $error("commit without write latch");
   commit_busy_a: assert property (arr_commit_out |-> ##[0:3] busy_out)
      else $error("commit without write cycle");
   busy_len_a: assert property ($rose(busy_out) |->
      (busy_out throughout ##BLO 1'b1) ##[1:4] !busy_out)
      else $error("write cycle length wrong");
   wel_clr_a: assert property ($fell(busy_out) |-> !status_out[1])
      else $error("latch not cleared after write");
   so_hold_a: assert property ($rose(sck_in) && so_oe_out |=>
      ($stable(so_out) || !so_oe_out) [*3])
      else $error("output moved after clock rise");
   commit_c: cover property (arr_commit_out);
   pause_c: cover property (!hold_n_in && !cs_n_in);
   busy_end_c: cover property ($fell(busy_out));
endmodule

// ==== spep_master.sv ====
/* Bus master model driving the serial pins.
   Assumes the bench calls its tasks; pins move on falling system clock edges. */
`timescale 1ns/1ps
module spep_master (
   // Clock
   input wire sys_clk_in,
   // Serial pins
   output reg cs_n_out,
   output reg sck_out,
   output reg si_out,
   output reg hold_n_out,
   input wire so_in,
   input wire so_oe_in
);
   initial begin
      cs_n_out = 1'b0;
      sck_out = 1'b0;
      si_out = 1'b0;
      hold_n_out = 1'b1;
   end
   task half;
      repeat (4) @(negedge sys_clk_in);
   endtask
   task sel;
      begin
         cs_n_out = 1'b0;
         half;
      end
   endtask
   task desel;
      begin
         half;
         cs_n_out = 1'b1;
         si_out = ~si_out;
         half;
      end
   endtask
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            si_out = tx[i];
            half;
            rx[i] = so_oe_in ? so_in : 1'bx;
            sck_out = 1'b1;
            half;
            sck_out = 1'b0;
         end
      end
   endtask
   // Junk clocks while paused must be ignored by the device
   task pause(input integer n, output reg oe_seen);
      integer i;
      begin
         oe_seen = 1'b0;
         half;
         hold_n_out = 1'b0;
         for (i = 0; i < 2 * n; i = i + 1) begin
            half;
            oe_seen = oe_seen | so_oe_in;
            sck_out = ~sck_out;
            si_out = ~si_out;
         end
         half;
         hold_n_out = 1'b1;
      end
   endtask
endmodule

// ==== test_spi_eeprom_pin_and_protect_logic.sv ====
/* Self-checking bench for spep_core.
   Assumes spep_core, spep_master and spep_chk in this folder. */
`timescale 1ns/1ps
module test_spi_eeprom_pin_and_protect_logic;
   reg sys_clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg wp_n_in = 1'b1;
   wire cs_n, sck, si, hold_n, so, so_oe, wr_pulse, commit, busy, standby;
   wire [10:0] addr;
   wire [7:0] wdata;
   wire [7:0] status;
   reg [7:0] rx;
   reg [7:0] last_wd;
   reg oe;
   reg [10:0] probe [0:2];
   integer n_errors = 0;
   integer total_checks = 0;
   integer commits = 0;
   integer bp, k, c;

   initial forever #20 sys_clk_in = ~sys_clk_in;

   spep_core #(.WRITE_CYCLES(20'd20)) dut (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sck_in(sck),
      .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe),
      .arr_addr_out(addr), .arr_wr_data_out(wdata), .arr_wr_out(wr_pulse),
      .arr_commit_out(commit), .arr_rd_data_in(addr[7:0] ^ 8'h5a),
      .status_out(status), .busy_out(busy), .standby_out(standby));
   spep_master m (
      .sys_clk_in(sys_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
      .hold_n_out(hold_n), .so_in(so), .so_oe_in(so_oe));

   always @(posedge sys_clk_in) begin
      if (commit)
         commits <= commits + 1;
      if (wr_pulse)
         last_wd <= wdata;
   end

   task check(input [7:0] seen, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask
   function prot(input [10:0] a, input [1:0] b);
      prot = b == 2'b11 || (b == 2'b10 && a >= 11'h400) || (b == 2'b01 && a >= 11'h600);
   endfunction
   task cmd(input [7:0] op);
      begin
         m.sel;
         m.xfer(op, rx);
         m.desel;
      end
   endtask
   // Array write (02h) or status write (01h); wpa is applied during the cycle
   task wr(input en, input [7:0] op, input [10:0] a, input [7:0] d, input wpa);
      begin
         if (en)
            cmd(8'h06);
         m.sel;
         m.xfer(op, rx);
         if (op == 8'h02) begin
            m.xfer({5'h00, a[10:8]}, rx);
            m.xfer(a[7:0], rx);
         end
         m.xfer(d, rx);
         m.desel;
         repeat (6) @(negedge sys_clk_in);
         wp_n_in = wpa;
         repeat (40) @(negedge sys_clk_in);
      end
   endtask
   task t_power;
      begin
         repeat (3) @(negedge sys_clk_in);
         rstn_in = 1'b1;
         @(negedge sys_clk_in);
         check(status, 8'h00);
         check({7'h00, so_oe}, 8'h00);
         check({7'h00, standby}, 8'h01);
         m.xfer(8'h06, rx);
         m.desel;
         check(status, 8'h00);
         cmd(8'h00);
      end
   endtask
   task t_latch;
      begin
         cmd(8'h06);
         check(status, 8'h02);
         cmd(8'h04);
         check(status, 8'h00);
         c = commits;
         wr(1'b0, 8'h02, 11'h010, 8'h33, 1'b1);
         check(commits[7:0], c[7:0]);
      end
   endtask
   task t_protect;
      begin
         probe[0] = 11'h3ff;
         probe[1] = 11'h5ff;
         probe[2] = 11'h600;
         for (bp = 0; bp < 4; bp = bp + 1) begin
            wr(1'b1, 8'h01, 11'h000, {4'h0, bp[1:0], 2'b00}, 1'b1);
            check(status, {4'h0, bp[1:0], 2'b00});
            for (k = 0; k < 3; k = k + 1) begin
               c = commits;
               wr(1'b1, 8'h02, probe[k], k[7:0] + 8'h40, 1'b1);
               check(commits[7:0], c[7:0] + {7'h00, !prot(probe[k], bp[1:0])});
               if (!prot(probe[k], bp[1:0]))
                  check(last_wd, k[7:0] + 8'h40);
            end
         end
      end
   endtask
   task t_wp;
      begin
         wr(1'b1, 8'h01, 11'h000, 8'h80, 1'b1);
         check(status, 8'h80);
         wp_n_in = 1'b0;
         wr(1'b1, 8'h01, 11'h000, 8'h84, 1'b0);
         check({status[7:2], 2'b00}, 8'h80);
         cmd(8'h04);
         c = commits;
         wr(1'b1, 8'h02, 11'h020, 8'h55, 1'b1);
         check(commits[7:0], c[7:0] + 8'h01);
         wr(1'b1, 8'h01, 11'h000, 8'h84, 1'b0);
         check(status, 8'h84);
         wp_n_in = 1'b1;
         wr(1'b1, 8'h01, 11'h000, 8'h00, 1'b0);
         wr(1'b1, 8'h01, 11'h000, 8'h08, 1'b0);
         check(status, 8'h08);
      end
   endtask
   task t_read;
      begin
         m.sel;
         m.xfer(8'h03, rx);
         m.xfer(8'h04, rx);
         m.xfer(8'h20, rx);
         m.xfer(8'h00, rx);
         check(rx, 8'h20 ^ 8'h5a);
         m.pause(3, oe);
         check({7'h00, oe}, 8'h00);
         m.xfer(8'h00, rx);
         check(rx, 8'h21 ^ 8'h5a);
         m.desel;
         m.sel;
         m.xfer(8'h05, rx);
         m.xfer(8'h00, rx);
         check(rx, 8'h08);
         m.desel;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   initial begin
      t_power;
      t_latch;
      t_protect;
      t_wp;
      t_read;
      final_report;
   end
   initial begin
      #2000000;
      n_errors = n_errors + 1;
      final_report;
   end
endmodule

bind spep_core spep_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
   .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
   .hold_n_in(hold_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
   .arr_commit_out(arr_commit_out), .status_out(status_out), .busy_out(busy_out),
   .standby_out(standby_out));
